// *** logic/flash_burst_port.sv ***
module flash_burst_port
	import flash_burst_pkg::*;
#(
	parameter int ADDR_W = 23,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// flash bus control pins
	input wire logic clk_k,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic latch_en_n,
	input wire logic burst_adv_n,
	input wire logic powerdown_n,
	input wire logic [ADDR_W-1:0] addr,
	// flash data pins and wait indicator
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe,
	output logic data_ready,
	// array read port
	output logic [ADDR_W-1:0] array_addr,
	input wire logic [DATA_W-1:0] array_rdata
);
	typedef struct packed {
		// configuration
		logic [2:0] burst_len;
		logic edge_sel;
		logic ready_timing;
		logic ylat;
		logic [3:0] xlat;
		logic read_mode;
		logic x32;
		// axi slave
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		// burst engine
		burst_state_t state;
		logic armed;
		logic [3:0] lcnt;
		logic ycnt;
		logic [ADDR_W-1:0] baddr;
		logic misaligned;
		logic waited;
		logic wait_st;
		logic [DATA_W-1:0] dq;
	} port_regs_t;

	port_regs_t st_ff;
	port_regs_t nxt_st;

	logic act;
	logic le_rise;
	logic sync_en;
	logic capture;
	logic cont;
	logic adv_slot;
	logic need_wait;
	logic [ADDR_W-1:0] next_addr;
	logic [16:0] cfg_word;
	logic [31:0] status_word;
	logic [31:0] merged;
	logic [1:0] page_mask;

	pin_evt_if evt ();

	assign evt.clk_k = clk_k;
	assign evt.latch_en_n = latch_en_n;
	assign evt.edge_sel = st_ff.edge_sel;
	assign act = evt.active_edge;
	assign le_rise = evt.le_rise;

	pin_edge_detect u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.evt(evt)
	);

	function automatic logic [3:0] xlat_cycles(input logic [3:0] code);
		xlat_cycles = code + XLAT_BIAS;
	endfunction : xlat_cycles

	// wrap within the burst length, or over the whole array
	function automatic logic [ADDR_W-1:0] wrap_next(
		input logic [ADDR_W-1:0] a,
		input logic [2:0] bl
	);
		logic [ADDR_W-1:0] mask;
		logic [ADDR_W-1:0] inc;
		mask = '0;
		inc = a + 1'b1;
		case (bl)
			BL_4: mask = ADDR_W'(3);
			BL_8: mask = ADDR_W'(7);
			BL_16: mask = ADDR_W'(15);
			default: mask = '1;
		endcase
		wrap_next = (a & ~mask) | (inc & mask);
	endfunction : wrap_next

	function automatic logic [31:0] mask_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		mask_merge = r;
	endfunction : mask_merge

	assign cfg_word = {st_ff.x32, st_ff.read_mode, st_ff.xlat, 1'b0,
		st_ff.ylat, st_ff.ready_timing, 1'b0, st_ff.edge_sel, 3'h0,
		st_ff.burst_len};
	assign status_word = {4'h0, st_ff.state == ST_STREAM && out_en_n &&
		burst_adv_n, st_ff.wait_st, st_ff.state, 1'b0,
		ADDR_W'(st_ff.baddr)};
	assign merged = mask_merge({15'h0, cfg_word}, st_ff.w_data, st_ff.w_strb);

	// burst gating and address capture
	assign sync_en = ~st_ff.read_mode & powerdown_n;
	assign capture = sync_en & st_ff.armed & ~chip_en_n & write_en_n &
		((act & ~latch_en_n) | le_rise);
	assign cont = st_ff.burst_len == BL_CONT;
	assign page_mask = st_ff.x32 ? 2'h1 : 2'h3;
	assign next_addr = wrap_next(st_ff.baddr, st_ff.burst_len);
	assign adv_slot = act & ~burst_adv_n & ~st_ff.ycnt;
	// one extra word slot at the first page crossing
	assign need_wait = cont & st_ff.misaligned & ~st_ff.waited &
		~st_ff.wait_st & ((next_addr[1:0] & page_mask) == 2'h0);

	always_comb begin
		nxt_st = st_ff;
		// write channel, address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (st_ff.aw_got && st_ff.w_got) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_SLVERR;
			if (st_ff.aw_addr == CFG_OFFSET) begin
				nxt_st.bresp = RESP_OKAY;
				nxt_st.burst_len = merged[BL_LSB +: 3];
				nxt_st.edge_sel = merged[EDGE_BIT];
				nxt_st.ready_timing = merged[READY_BIT];
				nxt_st.ylat = merged[YLAT_BIT];
				nxt_st.xlat = merged[XLAT_LSB +: 4];
				nxt_st.read_mode = merged[MODE_BIT];
				nxt_st.x32 = merged[X32_BIT];
			end else if (st_ff.aw_addr == STATUS_OFFSET) begin
				nxt_st.bresp = RESP_OKAY;
			end
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// read channel
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			case (s_axi_araddr[3:0])
				CFG_OFFSET: nxt_st.rdata = {15'h0, cfg_word};
				STATUS_OFFSET: nxt_st.rdata = status_word;
				default: begin
					nxt_st.rdata = 32'h0;
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end

		// re-arm capture once latch enable is seen high
		if (latch_en_n) begin
			nxt_st.armed = 1'b1;
		end else if (capture) begin
			nxt_st.armed = 1'b0;
		end

		case (st_ff.state)
			ST_IDLE: begin
				nxt_st.wait_st = 1'b0;
			end
			ST_LATENCY: begin
				if (act) begin
					nxt_st.lcnt = st_ff.lcnt - 4'h1;
					if (st_ff.lcnt == 4'h1) begin
						nxt_st.state = ST_STREAM;
						nxt_st.ycnt = 1'b0;
					end
				end
			end
			ST_STREAM: begin
				// advance high freezes everything in place
				if (act && !burst_adv_n && st_ff.ycnt) begin
					nxt_st.ycnt = 1'b0;
				end else if (adv_slot) begin
					nxt_st.ycnt = st_ff.ylat;
					if (need_wait) begin
						nxt_st.wait_st = 1'b1;
						nxt_st.waited = 1'b1;
					end else begin
						nxt_st.wait_st = 1'b0;
						nxt_st.baddr = next_addr;
					end
				end
			end
			default: begin
				nxt_st.state = ST_IDLE;
			end
		endcase

		// new address, also during a running burst
		if (capture) begin
			nxt_st.baddr = addr;
			nxt_st.state = ST_LATENCY;
			nxt_st.lcnt = xlat_cycles(st_ff.xlat);
			nxt_st.misaligned = (addr[1:0] & page_mask) != 2'h0;
			nxt_st.waited = 1'b0;
			nxt_st.wait_st = 1'b0;
		end

		// abort whatever the clock does
		if (chip_en_n || !sync_en) begin
			nxt_st.state = ST_IDLE;
		end

		nxt_st.dq = array_rdata;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.burst_len <= CFG_RESET[BL_LSB +: 3];
			st_ff.edge_sel <= CFG_RESET[EDGE_BIT];
			st_ff.ready_timing <= CFG_RESET[READY_BIT];
			st_ff.ylat <= CFG_RESET[YLAT_BIT];
			st_ff.xlat <= CFG_RESET[XLAT_LSB +: 4];
			st_ff.read_mode <= CFG_RESET[MODE_BIT];
			st_ff.x32 <= CFG_RESET[X32_BIT];
			st_ff.state <= ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// axi handshakes
	assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
	assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = ~st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	// flash side outputs
	assign array_addr = st_ff.baddr;
	assign dq_o = st_ff.dq;
	assign dq_oe = st_ff.state == ST_STREAM && !out_en_n && !chip_en_n &&
		sync_en;
	assign data_ready = ~(st_ff.wait_st | (st_ff.ready_timing &
		(st_ff.state == ST_STREAM) & ~burst_adv_n & ~st_ff.ycnt &
		need_wait));
endmodule : flash_burst_port

// *** shared/flash_burst_pkg.sv ***
// Overview of operation
// - capture at first active edge or le rise
// - first data only after initial latency
// - data drivers on only while oe low
// - advance counter per advance input, latency
// - continuous mode wraps whole array
// - advance high suspends continuous burst
// - misaligned continuous start drives wait low
// - ready timing bit moves wait one earlier
// - new le pulse restarts burst after latency
// - full latency invalid between overlapped bursts
// - oe and advance high suspend burst
// - oe low resumes, advance per input
// - chip enable high aborts, pins float
// - bursts only with read mode select zero
// - transitions on selected active clock edge
// - edge select zero falling, one rising
// - per-word latency two halves data rate
package flash_burst_pkg;
	localparam logic [3:0] CFG_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// configuration register fields
	localparam int BL_LSB = 0;
	localparam int EDGE_BIT = 6;
	localparam int READY_BIT = 8;
	localparam int YLAT_BIT = 9;
	localparam int XLAT_LSB = 11;
	localparam int MODE_BIT = 15;
	localparam int X32_BIT = 16;
	localparam logic [16:0] CFG_RESET = 17'h08000;
	localparam logic [2:0] BL_4 = 3'h1;
	localparam logic [2:0] BL_8 = 3'h2;
	localparam logic [2:0] BL_16 = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;
	localparam logic [3:0] XLAT_BIAS = 4'h5;
	// status register fields
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_STATE_LSB = 24;
	localparam int ST_WAIT_BIT = 26;
	localparam int ST_SUSP_BIT = 27;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LATENCY = 2'b01,
		ST_STREAM = 2'b11
	} burst_state_t;
endpackage : flash_burst_pkg

// *** shared/pin_evt_if.sv ***
interface pin_evt_if;
	logic clk_k;
	logic latch_en_n;
	logic edge_sel;
	logic active_edge;
	logic le_rise;
	modport src (
		input clk_k,
		input latch_en_n,
		input edge_sel,
		output active_edge,
		output le_rise
	);
	modport snk (
		output clk_k,
		output latch_en_n,
		output edge_sel,
		input active_edge,
		input le_rise
	);
endinterface : pin_evt_if

// *** logic/pin_edge_detect.sv ***
module pin_edge_detect
	import flash_burst_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin events
	pin_evt_if.src evt
);
	typedef struct packed {
		logic k;
		logic le_n;
	} edge_regs_t;

	edge_regs_t st_ff;
	edge_regs_t nxt_st;

	always_comb begin
		nxt_st.k = evt.clk_k;
		nxt_st.le_n = evt.latch_en_n;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '{k: 1'b0, le_n: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// selected edge of the flash clock
	assign evt.active_edge = evt.edge_sel ? (evt.clk_k & ~st_ff.k) :
		(~evt.clk_k & st_ff.k);
	assign evt.le_rise = evt.latch_en_n & ~st_ff.le_n;
endmodule : pin_edge_detect

// *** testbench/flash_host.sv ***
module flash_host (
	// clock
	input wire logic aclk,
	// flash pins
	output logic clk_k,
	output logic chip_en_n,
	output logic out_en_n,
	output logic write_en_n,
	output logic latch_en_n,
	output logic burst_adv_n,
	output logic powerdown_n,
	output logic [22:0] addr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{clk_k, chip_en_n, out_en_n, write_en_n} = 4'h7;
		{latch_en_n, burst_adv_n, powerdown_n} = 3'h7;
		addr = 23'h0;
	end
	// k only moves inside these tasks, idle low otherwise
	task automatic half();
		clk_k <= ~clk_k;
		repeat (3) @(posedge aclk);
	endtask : half
	task automatic kcyc(input int n);
		repeat (n) begin
			half();
			half();
		end
	endtask : kcyc
	task automatic pins(input logic ce_n, oe_n, adv_n);
		chip_en_n <= ce_n;
		out_en_n <= oe_n;
		burst_adv_n <= adv_n;
	endtask : pins
	task automatic aux(input logic pd_n);
		powerdown_n <= pd_n;
	endtask : aux
	task automatic latch(input logic [22:0] a);
		chip_en_n <= 1'b0;
		write_en_n <= 1'b1;
		latch_en_n <= 1'b0;
		addr <= a;
		kcyc(1);
		latch_en_n <= 1'b1;
		addr <= ~a;
	endtask : latch
endmodule : flash_host

// *** testbench/flash_burst_port_sva.sv ***
module flash_burst_port_sva #(
	parameter int ADDR_W = 23,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	// flash pins and array read port
	input wire logic clk_k,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic latch_en_n,
	input wire logic burst_adv_n,
	input wire logic [DATA_W-1:0] dq_o,
	input wire logic dq_oe,
	input wire logic data_ready,
	input wire logic [ADDR_W-1:0] array_addr,
	input wire logic [DATA_W-1:0] array_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wr_seen_ff;
	logic k_q_ff;
	logic le_q_ff;
	logic [2:0] quiet_ff;
	logic [3:0] ktog_ff;
	always_ff @(posedge aclk) begin
		k_q_ff <= clk_k;
		le_q_ff <= latch_en_n;
		if (!aresetn) begin
			wr_seen_ff <= 1'b0;
			quiet_ff <= 3'h7;
			ktog_ff <= 4'h0;
		end else begin
			wr_seen_ff <= wr_seen_ff | (s_axi_awvalid & s_axi_awready);
			if (clk_k != k_q_ff || latch_en_n != le_q_ff)
				quiet_ff <= 3'h0;
			else if (quiet_ff != 3'h7)
				quiet_ff <= quiet_ff + 3'h1;
			if (!latch_en_n)
				ktog_ff <= 4'h0;
			else if (clk_k != k_q_ff && ktog_ff != 4'hf)
				ktog_ff <= ktog_ff + 4'h1;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_frozen;
		(burst_adv_n && latch_en_n && !chip_en_n)[*4];
	endsequence
	sequence s_idle;
		chip_en_n[*3];
	endsequence
	property p_oe;
		out_en_n |-> !dq_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("oe gate");
	property p_abort;
		chip_en_n |-> !dq_oe;
	endproperty
	a_abort: assert property (p_abort) else $error("abort");
	property p_rdy;
		s_idle |-> data_ready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready idle");
	property p_freeze;
		s_frozen |-> $stable(array_addr);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze");
	property p_edge;
		!chip_en_n && !$stable(array_addr) |-> quiet_ff < 3'h4;
	endproperty
	a_edge: assert property (p_edge) else $error("no edge");
	property p_dq;
		dq_oe && $past(dq_oe) |-> dq_o == $past(array_rdata);
	endproperty
	a_dq: assert property (p_dq) else $error("dq data");
	property p_mode;
		!wr_seen_ff |-> !dq_oe;
	endproperty
	a_mode: assert property (p_mode) else $error("async mode");
	property p_lat;
		$rose(dq_oe) |-> ktog_ff >= 4'h9;
	endproperty
	a_lat: assert property (p_lat) else $error("latency");
endmodule : flash_burst_port_sva
bind flash_burst_port flash_burst_port_sva #(
	.ADDR_W(ADDR_W),
	.DATA_W(DATA_W)
) u_sva (.*);

// *** testbench/tb_flash_burst_port.sv ***
module tb_flash_burst_port
	import flash_burst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic wr;
		logic [3:0] off;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [1:0] rsp;
	} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr, s_axi_wdata;
	logic [31:0] s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, dq_oe, data_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic clk_k, chip_en_n, out_en_n, write_en_n, latch_en_n;
	logic burst_adv_n, powerdown_n;
	logic [22:0] addr, array_addr;
	logic [31:0] s_axi_rdata, dq_o, array_rdata, rd;
	int error_cnt = 0, cmp_count = 0, low_cnt = 0;
	row_t rows [5] = '{
		'{1'b0, 4'h0, 32'h0, 32'h8000, RESP_OKAY},
		'{1'b1, 4'h8, 32'h0, 32'h0, RESP_SLVERR},
		'{1'b0, 4'h8, 32'h0, 32'h0, RESP_SLVERR},
		'{1'b1, 4'h0, 32'h1842, 32'h0, RESP_OKAY},
		'{1'b0, 4'h0, 32'h0, 32'h1842, RESP_OKAY}
	};
	flash_burst_port u_flash_burst_port (.*);
	flash_host u_flash_host (.*);
	assign array_rdata = 32'(array_addr);
	always #20 aclk = ~aclk;
	always @(posedge aclk) if (!data_ready) low_cnt++;
	task automatic chk(input logic [47:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi(input logic wr, input logic [3:0] off,
		input logic [31:0] wd, input logic [3:0] strb = 4'hf);
		logic aw_ok, w_ok, ar_ok, done;
		s_axi_awaddr <= {28'h0, off};
		s_axi_araddr <= {28'h0, off};
		s_axi_wdata <= wd;
		s_axi_wstrb <= strb;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		do begin
			// look at the slave's answer while it is settled
			@(negedge aclk);
			aw_ok = s_axi_awready;
			w_ok = s_axi_wready;
			ar_ok = s_axi_arready;
			done = wr ? s_axi_bvalid : s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			if (ar_ok) s_axi_arvalid <= 1'b0;
		end while (!done);
		{s_axi_bready, s_axi_rready} <= 2'b00;
		@(posedge aclk);
	endtask : axi
	task automatic test_done();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		test_done();
	end
	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= 96'h0;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
		{s_axi_arvalid, s_axi_rready} <= 2'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({dq_oe, data_ready}, 2'b01);
		u_flash_host.latch(23'h5);
		u_flash_host.kcyc(10);
		chk(array_addr, 32'h0);
		foreach (rows[i]) begin
			axi(rows[i].wr, rows[i].off, rows[i].wd);
			chk(rsp, rows[i].rsp);
			if (!rows[i].wr) chk(rd, rows[i].rd);
		end
		u_flash_host.pins(1'b0, 1'b0, 1'b1);
		u_flash_host.latch(23'h12);
		u_flash_host.kcyc(7);
		chk(dq_oe, 1'b0);
		u_flash_host.kcyc(1);
		chk({dq_oe, dq_o}, 33'h100000012);
		u_flash_host.pins(1'b0, 1'b0, 1'b0);
		for (int i = 3; i < 11; i++) begin
			u_flash_host.kcyc(1);
			chk(array_addr, 32'h10 | (i % 8));
		end
		u_flash_host.pins(1'b0, 1'b1, 1'b1);
		u_flash_host.kcyc(3);
		chk({dq_oe, array_addr}, 24'h12);
		u_flash_host.pins(1'b0, 1'b0, 1'b1);
		u_flash_host.kcyc(1);
		chk({dq_oe, dq_o}, 33'h100000012);
		u_flash_host.latch(23'h30);
		chk(dq_oe, 1'b0);
		u_flash_host.kcyc(8);
		chk({dq_oe, dq_o}, 33'h100000030);
		u_flash_host.pins(1'b1, 1'b0, 1'b1);
		@(posedge aclk);
		chk(dq_oe, 1'b0);
		axi(1'b0, 4'h4, 0);
		chk(rd[25:24], 2'b00);
		axi(1'b1, 4'h0, 32'hffffff07, 4'h1);
		chk(rsp, RESP_OKAY);
		axi(1'b0, 4'h0, 0);
		chk(rd, 32'h1807);
		u_flash_host.latch(23'h1);
		u_flash_host.kcyc(8);
		chk(dq_oe, 1'b1);
		u_flash_host.pins(1'b0, 1'b0, 1'b0);
		u_flash_host.half();
		chk(array_addr, 32'h1);
		u_flash_host.half();
		chk(array_addr, 32'h2);
		low_cnt = 0;
		u_flash_host.kcyc(3);
		chk({array_addr, low_cnt != 0}, 24'h9);
		u_flash_host.pins(1'b0, 1'b0, 1'b1);
		u_flash_host.latch(23'h7ffffc);
		u_flash_host.kcyc(8);
		low_cnt = 0;
		u_flash_host.pins(1'b0, 1'b0, 1'b0);
		u_flash_host.kcyc(4);
		chk({array_addr, low_cnt != 0}, 24'h0);
		chk(dq_oe, 1'b1);
		u_flash_host.aux(1'b0);
		@(posedge aclk);
		chk(dq_oe, 1'b0);
		test_done();
	end
endmodule : tb_flash_burst_port
